// >>> shared/rgc_pkg.sv
// Shared constants for the receive gain, filter and calibration control
package rgc_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0] REG_RX_CTRL    = 8'h07;
	localparam logic [7:0] REG_FILT_TGT   = 8'h08;
	localparam int         CTRL_LPF_EN    = 0;
	localparam int         CTRL_OCAL_BUSY = 5;
	localparam int         CTRL_FCAL_BUSY = 6;
	localparam logic [7:0] CTRL_RST       = 8'h01;
	localparam logic [7:0] TGT_RST        = 8'h80;

	// ****************************************
	// Gain mapping
	// ****************************************
	localparam int         GAIN_W       = 6;
	localparam int         STG_W        = 3;
	localparam logic [5:0] GAIN_MAX_IDX = 6'h3c;
	localparam logic [2:0] RED_MAX_STEP = 3'h6;
	localparam int         RED_STEP_DB  = 8;
	localparam int         COARSE_DB    = 6;
	localparam logic [2:0] S1_MAX       = 3'h4;
	localparam logic [2:0] S2_MAX       = 3'h5;
	localparam logic [2:0] FINE_MAX     = 3'h6;

	// ****************************************
	// Calibration timing and servo
	// ****************************************
	localparam int                CLK_MHZ       = 250;
	localparam int                FCAL_MAX_US   = 100;
	localparam int                FCAL_CYC      = FCAL_MAX_US * CLK_MHZ - 1;
	localparam int                ADC_W         = 12;
	localparam logic signed [11:0] OFS_WIN      = 12'sh020;
	localparam logic [7:0]        OFS_DAC_MID   = 8'h80;

endpackage

// >>> shared/rgc_link_if.sv
// Carrier between the control top, the gain table and the offset servo
`timescale 1ns/1ps
interface rgc_link_if;
	logic [rgc_pkg::GAIN_W-1:0]        gain_code;
	logic                              gain_reduced;
	logic [rgc_pkg::STG_W-1:0]         stage1;
	logic [rgc_pkg::STG_W-1:0]         stage2;
	logic [rgc_pkg::STG_W-1:0]         fine;
	logic                              start;
	logic                              busy;
	logic                              done;
	logic                              valid;
	logic signed [rgc_pkg::ADC_W-1:0]  offset;
	logic [7:0]                        dac;

	modport lut_mp (input gain_code, gain_reduced,
		output stage1, stage2, fine);
	modport servo_mp (input start, valid, offset,
		output busy, done, dac);
	modport top_mp (output gain_code, gain_reduced, start, valid, offset,
		input stage1, stage2, fine, busy, done, dac);
endinterface

// >>> design/rgc_gain_lut.sv
// Gain word to coarse and fine stage settings table
`timescale 1ns/1ps
module rgc_gain_lut (
	rgc_link_if.lut_mp lnk
);

	// ****************************************
	// Split a 0..60 dB index into stage steps
	// ****************************************
	function automatic logic [8:0] rgc_split(input logic [5:0] idx);
		logic [3:0] crs;
		logic [2:0] s1;
		logic [5:0] rem;
		crs = 4'(idx / 6'h06);
		if (crs > 4'h9) begin
			crs = 4'h9; // Top code rides on the fine stage
		end
		s1 = (crs > 4'(rgc_pkg::S1_MAX)) ? rgc_pkg::S1_MAX : crs[2:0];
		rem = idx - 6'(crs * 4'h6);
		rgc_split = {s1, 3'(crs - 4'(s1)), rem[2:0]};
	endfunction

	logic [5:0] idx;
	logic [2:0] step;

	// Plain or reduced mapping, out of range codes clamp
	always_comb begin
		step = (lnk.gain_code[2:0] > rgc_pkg::RED_MAX_STEP) ?
			rgc_pkg::RED_MAX_STEP : lnk.gain_code[2:0];
		if (lnk.gain_reduced) begin
			idx = {step, 3'h0};
		end else if (lnk.gain_code > rgc_pkg::GAIN_MAX_IDX) begin
			idx = rgc_pkg::GAIN_MAX_IDX;
		end else begin
			idx = lnk.gain_code;
		end
	end

	// Table lookup feeding every stage
	assign {lnk.stage1, lnk.stage2, lnk.fine} = rgc_split(idx);

endmodule

// >>> design/rgc_offset_servo.sv
// Digital servo that trims the offset calibration DAC
`timescale 1ns/1ps
module rgc_offset_servo #(
	parameter int DAC_W = 8
) (
	// Clock and reset
	input  wire logic   mclk_i,
	input  wire logic   rst_i,
	// Link to control top
	rgc_link_if.servo_mp lnk
);

	logic             busy_reg;
	logic             done_reg;
	logic [7:0]       dac_reg;
	logic [DAC_W:0]   iter_reg;
	logic             in_win;

	assign in_win = (lnk.offset <= rgc_pkg::OFS_WIN) &&
		(lnk.offset >= -rgc_pkg::OFS_WIN);

	// Step the DAC one code per sample until the offset is in the window;
	// the step cap stops a stuck loop from holding the gain forced forever
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
			dac_reg  <= 8'h00;
			iter_reg <= '0;
		end else begin
			done_reg <= 1'b0;
			if (lnk.start) begin
				busy_reg <= 1'b1;
				dac_reg  <= rgc_pkg::OFS_DAC_MID;
				iter_reg <= '0;
			end else if (busy_reg && lnk.valid) begin
				iter_reg <= iter_reg + 1'b1;
				if (in_win || iter_reg[DAC_W]) begin
					busy_reg <= 1'b0;
					done_reg <= 1'b1;
				end else if (lnk.offset > 0 && dac_reg != 8'h00) begin
					dac_reg <= dac_reg - 8'h01;
				end else if (lnk.offset < 0 && dac_reg != 8'hff) begin
					dac_reg <= dac_reg + 8'h01;
				end
			end
		end
	end

	assign lnk.busy = busy_reg;
	assign lnk.done = done_reg;
	assign lnk.dac  = dac_reg;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);

	servo_settle_a: assert property (
		busy_reg && lnk.valid && in_win &&
		!lnk.start |=> !busy_reg && done_reg)
		else $error("servo did not stop inside window");
	servo_step_a: assert property (
		busy_reg && lnk.valid && !in_win &&
		!iter_reg[DAC_W] && lnk.offset > 0 && dac_reg != 8'h00 &&
		!lnk.start |=> dac_reg == $past(dac_reg) - 8'h01)
		else $error("servo did not step down");
	servo_done_c: cover property (busy_reg ##1 done_reg);

endmodule

// >>> design/rgc_rx_ctrl.sv
// Receive gain, low-pass filter and calibration control top
`timescale 1ns/1ps
module rgc_rx_ctrl #(
	parameter int FCAL_CYCLES = rgc_pkg::FCAL_CYC,
	parameter int DAC_W       = 8
) (
	// Clock and reset
	input  wire logic                         mclk_i,
	input  wire logic                         rst_i,
	// Serial port register access
	input  wire logic [7:0]                   reg_addr_i,
	input  wire logic [7:0]                   reg_wdata_i,
	input  wire logic                         reg_wr_i,
	input  wire logic                         reg_rd_i,
	output logic [7:0]                        reg_rdata_o,
	// Gain request and offset calibration request
	input  wire logic [rgc_pkg::GAIN_W-1:0]   gain_code_i,
	input  wire logic                         gain_reduced_i,
	input  wire logic                         offset_cal_req_i,
	// Converter offset measurement
	input  wire logic                         adc_valid_i,
	input  wire logic [rgc_pkg::ADC_W-1:0]    adc_offset_i,
	// Receive gain amp settings
	output logic [rgc_pkg::STG_W-1:0]         coarse_stage1_o,
	output logic [rgc_pkg::STG_W-1:0]         coarse_stage2_o,
	output logic [rgc_pkg::STG_W-1:0]         fine_gain_o,
	// Offset cancellation
	output logic                              input_short_o,
	output logic [7:0]                        cal_dac_o,
	output logic                              offset_cal_busy_o,
	// Receive lowpass
	output logic                              receive_lowpass_en_o,
	output logic [7:0]                        filter_target_o,
	output logic                              filter_cal_busy_o,
	output logic                              filter_cal_done_o
);

	// ****************************************
	// Register file
	// ****************************************
	localparam logic [7:0] STAT_MASK =
		8'(1 << rgc_pkg::CTRL_OCAL_BUSY) | 8'(1 << rgc_pkg::CTRL_FCAL_BUSY);

	logic [7:0]  ctrl_reg;
	logic [7:0]  tgt_reg;
	logic        wr_ctrl;
	logic        wr_tgt;
	logic [7:0]  ctrl_view;

	assign wr_ctrl = reg_wr_i && reg_addr_i == rgc_pkg::REG_RX_CTRL;
	assign wr_tgt  = reg_wr_i && reg_addr_i == rgc_pkg::REG_FILT_TGT;

	// Busy flags overlay the control word so software can poll them
	always_comb begin
		ctrl_view = ctrl_reg & ~STAT_MASK;
		ctrl_view[rgc_pkg::CTRL_OCAL_BUSY] = offset_cal_busy_o;
		ctrl_view[rgc_pkg::CTRL_FCAL_BUSY] = filter_cal_busy_o;
	end

	// Control word, filter enabled out of reset
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			ctrl_reg <= rgc_pkg::CTRL_RST;
		end else if (wr_ctrl) begin
			ctrl_reg <= reg_wdata_i;
		end
	end

	// Cutoff target, written by software
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			tgt_reg <= rgc_pkg::TGT_RST;
		end else if (wr_tgt) begin
			tgt_reg <= reg_wdata_i;
		end
	end

	// Read data, one cycle after the strobe; unknown addresses read zero
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			reg_rdata_o <= 8'h00;
		end else if (reg_rd_i) begin
			case (reg_addr_i)
				rgc_pkg::REG_RX_CTRL: begin
					reg_rdata_o <= ctrl_view;
				end
				rgc_pkg::REG_FILT_TGT: begin
					reg_rdata_o <= tgt_reg;
				end
				default: begin
					reg_rdata_o <= 8'h00;
				end
			endcase
		end
	end

	assign receive_lowpass_en_o = ctrl_reg[rgc_pkg::CTRL_LPF_EN];
	assign filter_target_o      = tgt_reg;

	// ****************************************
	// Filter calibration
	// ****************************************
	typedef enum logic {FC_IDLE, FC_RUN} rgc_fcal_type;

	rgc_fcal_type fc_state_reg;
	logic [15:0]  fc_cnt_reg;
	logic         fc_done_reg;

	// Any target write, same value or not, restarts the count; a late
	// write simply discards the run in progress
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			fc_state_reg <= FC_IDLE;
			fc_cnt_reg   <= 16'h0000;
			fc_done_reg  <= 1'b0;
		end else begin
			fc_done_reg <= 1'b0;
			if (wr_tgt) begin
				fc_state_reg <= FC_RUN;
				fc_cnt_reg   <= 16'h0000;
			end else begin
				case (fc_state_reg)
					FC_RUN: begin
						if (fc_cnt_reg == 16'(FCAL_CYCLES - 1)) begin
							fc_state_reg <= FC_IDLE;
							fc_done_reg  <= 1'b1;
						end else begin
							fc_cnt_reg <= fc_cnt_reg + 16'h0001;
						end
					end
					default: begin
						fc_state_reg <= FC_IDLE;
					end
				endcase
			end
		end
	end

	assign filter_cal_busy_o = fc_state_reg == FC_RUN;
	assign filter_cal_done_o = fc_done_reg;

	// ****************************************
	// Offset cancellation sequencing
	// ****************************************
	rgc_link_if lnk ();

	logic pwrup_pend_reg;

	// Power-up run is owed from reset until the servo accepts it
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			pwrup_pend_reg <= 1'b1;
		end else if (lnk.start) begin
			pwrup_pend_reg <= 1'b0;
		end
	end

	// Requests while a run is busy are dropped, the run already covers them
	assign lnk.start  = (pwrup_pend_reg || offset_cal_req_i) &&
		!lnk.busy;
	assign lnk.valid  = adc_valid_i;
	assign lnk.offset = adc_offset_i;
	assign lnk.gain_code    = gain_code_i;
	assign lnk.gain_reduced = gain_reduced_i;

	rgc_offset_servo #(
		.DAC_W (DAC_W)
	) u_servo (
		.mclk_i (mclk_i),
		.rst_i  (rst_i),
		.lnk    (lnk)
	);

	rgc_gain_lut u_lut (
		.lnk (lnk)
	);

	assign offset_cal_busy_o = lnk.busy;
	assign cal_dac_o         = lnk.dac;

	// ****************************************
	// Stage settings
	// ****************************************
	// Registered so a gain change never glitches the analog switches
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			coarse_stage1_o <= '0;
			coarse_stage2_o <= '0;
			fine_gain_o     <= '0;
			input_short_o   <= 1'b0;
		end else if (lnk.busy) begin
			coarse_stage1_o <= rgc_pkg::S1_MAX;
			coarse_stage2_o <= rgc_pkg::S2_MAX;
			fine_gain_o     <= rgc_pkg::FINE_MAX;
			input_short_o   <= 1'b1;
		end else begin
			coarse_stage1_o <= lnk.stage1;
			coarse_stage2_o <= lnk.stage2;
			fine_gain_o     <= lnk.fine;
			input_short_o   <= 1'b0;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);

	int gain_db;
	assign gain_db = rgc_pkg::COARSE_DB *
		(int'(coarse_stage1_o) + int'(coarse_stage2_o)) + int'(fine_gain_o);

	fcal_start_a: assert property (
		wr_tgt |=> filter_cal_busy_o &&
		filter_target_o == $past(reg_wdata_i))
		else $error("target write did not start calibration");
	fcal_len_a: assert property (
		filter_cal_done_o |->
		$past(fc_cnt_reg) == 16'(FCAL_CYCLES - 1) &&
		FCAL_CYCLES <= rgc_pkg::FCAL_CYC)
		else $error("filter calibration length wrong");
	fcal_restart_a: assert property (
		filter_cal_busy_o && wr_tgt |=>
		fc_cnt_reg == 16'h0000 && !filter_cal_done_o)
		else $error("late target write did not restart");
	lpf_bypass_a: assert property (
		wr_ctrl && !reg_wdata_i[0] |=>
		!receive_lowpass_en_o)
		else $error("filter not bypassed");
	ocal_boot_a: assert property (
		$fell(rst_i) |-> ##[0:1]
		offset_cal_busy_o)
		else $error("no offset run after reset");
	ocal_req_a: assert property (
		offset_cal_req_i && !offset_cal_busy_o
		|=> offset_cal_busy_o)
		else $error("offset request ignored");
	ocal_force_a: assert property (
		$past(offset_cal_busy_o) |->
		input_short_o && coarse_stage1_o == rgc_pkg::S1_MAX &&
		coarse_stage2_o == rgc_pkg::S2_MAX &&
		fine_gain_o == rgc_pkg::FINE_MAX)
		else $error("gain not forced during offset run");
	gain_full_a: assert property (
		!offset_cal_busy_o && !gain_reduced_i &&
		gain_code_i <= rgc_pkg::GAIN_MAX_IDX |=> gain_db ==
		int'($past(gain_code_i)) && fine_gain_o <= rgc_pkg::FINE_MAX)
		else $error("gain table mismatch");
	gain_red_a: assert property (
		!offset_cal_busy_o && gain_reduced_i &&
		gain_code_i[2:0] <= rgc_pkg::RED_MAX_STEP |=> gain_db ==
		rgc_pkg::RED_STEP_DB * int'($past(gain_code_i[2:0])))
		else $error("reduced gain mismatch");
	// Servo end pulse must release the input short on the next edge
	ocal_end_a: assert property (
		lnk.done |=> !input_short_o)
		else $error("input short held after offset run");

	fcal_done_c: cover property (filter_cal_busy_o ##1 filter_cal_done_o);
	fcal_rest_c: cover property (filter_cal_busy_o && wr_tgt);
	ocal_req_c:  cover property (offset_cal_req_i ##1 offset_cal_busy_o);

endmodule

// >>> tb/rgc_adc_model.sv
// Behavioural converter that reports residual offset versus trim DAC code
`timescale 1ns/1ps
module rgc_adc_model #(
	parameter int BASE_OFS = 100
) (
	// Clock and reset
	input  wire logic        mclk_i,
	input  wire logic        rst_i,
	// Trim DAC seen by the front end
	input  wire logic [7:0]  cal_dac_i,
	// Offset samples
	output logic             adc_valid_o,
	output logic [11:0]      adc_offset_o
);
	logic [1:0] ph_reg;

	// One sample every four cycles so the trim settles in between
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			ph_reg       <= 2'h0;
			adc_valid_o  <= 1'b0;
			adc_offset_o <= 12'h000;
		end else begin
			ph_reg      <= ph_reg + 2'h1;
			adc_valid_o <= (ph_reg == 2'h3);
			// Lower code pulls the offset down by eight codes a step
			if (ph_reg == 2'h3)
				adc_offset_o <= 12'(BASE_OFS + 8 * (int'(cal_dac_i) - 128));
			else
				adc_offset_o <= ~adc_offset_o; // Stale value is not held
		end
	end
endmodule

// >>> tb/rgc_rx_ctrl_bench.sv
// Self-checking bench for the receive gain, filter and calibration control
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
	n_mismatch++; $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module rgc_rx_ctrl_bench;
	// ****************************************
	// Signals and instances
	// ****************************************
	localparam int FCAL = 20; // Short count keeps the run brief
	logic        mclk_i;
	logic        rst_i;
	logic [7:0]  reg_addr_i;
	logic [7:0]  reg_wdata_i;
	logic        reg_wr_i;
	logic        reg_rd_i;
	logic [7:0]  reg_rdata_o;
	logic [5:0]  gain_code_i;
	logic        gain_reduced_i;
	logic        offset_cal_req_i;
	logic        adc_valid_i;
	logic [11:0] adc_offset_i;
	logic [2:0]  s1;
	logic [2:0]  s2;
	logic [2:0]  fn;
	logic        short_w;
	logic [7:0]  dac;
	logic        obusy;
	logic        lpf_en;
	logic [7:0]  tgt;
	logic        fbusy;
	logic        fdone;
	int          n_mismatch;
	int          cmp_count;
	int          n_done;
	int          i;

	rgc_rx_ctrl #(.FCAL_CYCLES(FCAL), .DAC_W(8)) dut (
		.mclk_i(mclk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o), .gain_code_i(gain_code_i),
		.gain_reduced_i(gain_reduced_i), .offset_cal_req_i(offset_cal_req_i),
		.adc_valid_i(adc_valid_i), .adc_offset_i(adc_offset_i),
		.coarse_stage1_o(s1), .coarse_stage2_o(s2), .fine_gain_o(fn),
		.input_short_o(short_w), .cal_dac_o(dac), .offset_cal_busy_o(obusy),
		.receive_lowpass_en_o(lpf_en), .filter_target_o(tgt),
		.filter_cal_busy_o(fbusy), .filter_cal_done_o(fdone));

	rgc_adc_model adc (.mclk_i(mclk_i), .rst_i(rst_i), .cal_dac_i(dac),
		.adc_valid_o(adc_valid_i), .adc_offset_o(adc_offset_i));

	// Clock and done pulse counter
	initial begin
		mclk_i = 1'b0;
		forever #2 mclk_i = ~mclk_i;
	end
	// Falling edge sampling keeps clear of the launching edge
	always @(negedge mclk_i) if (fdone === 1'b1) n_done++;

	// ****************************************
	// Access tasks
	// ****************************************
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		reg_addr_i  <= a;
		reg_wdata_i <= d;
		reg_wr_i    <= 1'b1;
		@(posedge mclk_i);
		reg_wr_i <= 1'b0;
		#1;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge mclk_i);
		reg_addr_i <= a;
		reg_rd_i   <= 1'b1;
		@(posedge mclk_i);
		reg_rd_i <= 1'b0;
		#1;
		`CHK("rdata", e, reg_rdata_o)
	endtask

	// Busy must last exactly the set count and end with done
	task automatic fcal_len();
		int c;
		c = 0;
		while (fbusy === 1'b1 && c < 100) begin
			c++;
			@(posedge mclk_i);
			#1;
		end
		`CHK("fcal_len", FCAL, c)
		`CHK("fdone", 1'b1, fdone)
	endtask

	// Model settles at code 0x77, first code within 32 of zero
	task automatic ocal_wait();
		int c;
		c = 0;
		while (obusy === 1'b1 && c < 500) begin
			c++;
			@(posedge mclk_i);
			#1;
		end
		`CHK("ocal_busy", 1'b0, obusy)
		`CHK("cal_dac", 8'h77, dac)
	endtask

	// Table outputs one edge after the gain word changes
	task automatic gchk(input logic [5:0] g, input logic r, input int e);
		int c;
		c = (e / 6 > 9) ? 9 : e / 6;
		@(posedge mclk_i);
		gain_code_i    <= g;
		gain_reduced_i <= r;
		@(posedge mclk_i);
		#1;
		`CHK("stages", {3'(c > 4 ? 4 : c), 3'(c > 4 ? c - 4 : 0),
			3'(e - 6 * c)}, {s1, s2, fn})
	endtask

	task automatic results();
		$display("compares %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Hang guard, far beyond the expected 330 cycles
	initial begin
		repeat (6000) @(posedge mclk_i);
		n_mismatch++;
		$display("watchdog expired");
		results();
	end

	// ****************************************
	// Test sequence
	// ****************************************
	initial begin
		n_mismatch = 0;
		cmp_count = 0;
		n_done = 0;
		rst_i = 1'b1;
		reg_addr_i = 8'h00;
		reg_wdata_i = 8'h00;
		reg_wr_i = 1'b0;
		reg_rd_i = 1'b0;
		gain_code_i = 6'h0c;
		gain_reduced_i = 1'b0;
		offset_cal_req_i = 1'b0;
		repeat (12) @(posedge mclk_i);
		rst_i <= 1'b0;
		repeat (3) @(posedge mclk_i);
		#1;
		`CHK("lpf_default", 1'b1, lpf_en)
		`CHK("tgt_reset", 8'h80, tgt)
		`CHK("pwrup_busy", 1'b1, obusy)
		`CHK("short", 1'b1, short_w)
		`CHK("forced", {3'h4, 3'h5, 3'h6}, {s1, s2, fn})
		rd(rgc_pkg::REG_RX_CTRL, 8'h21);
		ocal_wait();
		@(posedge mclk_i);
		offset_cal_req_i <= 1'b1;
		@(posedge mclk_i);
		offset_cal_req_i <= 1'b0;
		#1;
		`CHK("req_busy", 1'b1, obusy)
		`CHK("dac_mid", 8'h80, dac)
		// A request while busy must be dropped, not restart the trim
		repeat (10) @(posedge mclk_i);
		offset_cal_req_i <= 1'b1;
		@(posedge mclk_i);
		offset_cal_req_i <= 1'b0;
		#1;
		`CHK("req_drop", 1'b1, dac < 8'h80)
		ocal_wait();
		@(posedge mclk_i);
		#1;
		`CHK("short_off", 1'b0, short_w)
		$display("offset test done");

		// Full gain word sweep, codes above 60 clamp
		for (i = 0; i < 64; i++)
			gchk(6'(i), 1'b0, (i > 60) ? 60 : i);
		// Reduced map, upper bits must be ignored
		for (i = 0; i < 8; i++)
			gchk({3'h7, 3'(i)}, 1'b1, 8 * ((i > 6) ? 6 : i));
		$display("gain test done");

		wr(rgc_pkg::REG_FILT_TGT, 8'h35);
		`CHK("tgt", 8'h35, tgt)
		fcal_len();
		wr(rgc_pkg::REG_FILT_TGT, 8'h35);
		fcal_len();
		wr(rgc_pkg::REG_FILT_TGT, 8'h40);
		repeat (5) @(posedge mclk_i);
		wr(rgc_pkg::REG_FILT_TGT, 8'h5a);
		fcal_len();
		rd(rgc_pkg::REG_FILT_TGT, 8'h5a);
		`CHK("done_count", 3, n_done)
		$display("filter test done");

		wr(rgc_pkg::REG_RX_CTRL, 8'h00);
		`CHK("lpf_off", 1'b0, lpf_en)
		rd(rgc_pkg::REG_RX_CTRL, 8'h00);
		wr(rgc_pkg::REG_RX_CTRL, 8'h61);
		`CHK("lpf_on", 1'b1, lpf_en)
		rd(rgc_pkg::REG_RX_CTRL, 8'h01);
		wr(8'h05, 8'hff);
		rd(8'h05, 8'h00);
		rd(rgc_pkg::REG_RX_CTRL, 8'h01);
		`CHK("no_fcal", 3, n_done)
		$display("register test done");
		results();
	end
endmodule
